// ### pkg/sfr_pkg.sv
/*
 Constants, types and the command decoder of the serial flash read front end.
 Assumes a 40 MHz system clock and a host that owns the serial clock.
*/
// Overview of operation
// - Entry command sets quad mode; host waits.
// - Exit command or register write leaves quad.
// - Any reset reloads quad from nonvolatile bit.
// - Exit command clears quad; host waits.
// - Instruction one bit per rise; quad four.
// - DDR reads move address and data twice.
// - Address length bit widens address to four.
// - Address bits above 23 are ignored.
// - Mode bits follow address on quad reads.
// - Inputs during dummy cycles are ignored.
// - Latency code sets dummy falls count.
// - Zero dummy: data on releasing fall.
// - DDR dummy end drives eight edge pattern.
// - Chip select high ends the read.
// - Basic read: 3/4 byte address, no latency.
// - Fast read: dummy cycles, single output.
// - Dual output read: two bits per fall.
// - Address increments per byte, wraps zero.
// - Mode nibble A skips next instruction.
package sfr_pkg;
   // Command codes
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_READ4 = 8'h13;
   localparam logic [7:0] CMD_FAST = 8'h0b;
   localparam logic [7:0] CMD_FAST4 = 8'h0c;
   localparam logic [7:0] CMD_DUAL = 8'h3b;
   localparam logic [7:0] CMD_DUAL4 = 8'h3c;
   localparam logic [7:0] CMD_QRD = 8'heb;
   localparam logic [7:0] CMD_QDDR = 8'hed;
   localparam logic [7:0] CMD_QEN = 8'h38;
   localparam logic [7:0] CMD_QEX = 8'hf5;
   // Continuous read mode nibble
   localparam logic [3:0] MODE_CONT = 4'ha;
   // Volatile configuration 2 layout
   localparam int CFG2_ALEN = 0;
   localparam int CFG2_QUAD = 3;
   localparam logic [7:0] CFG2_RST = 8'h00;
   localparam logic [7:0] CFG2_WMASK = 8'h09;
   // Field lengths in bits
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] MODE_BITS = 6'h08;
   localparam logic [5:0] ALEN3 = 6'h18;
   localparam logic [5:0] ALEN4 = 6'h20;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int ADDR_W = 24;
   // Lane widths per edge
   localparam logic [2:0] W1 = 3'h1;
   localparam logic [2:0] W2 = 3'h2;
   localparam logic [2:0] W4 = 3'h4;
   // Output enables, low drives
   localparam logic [3:0] OE_W1 = 4'hd;
   localparam logic [3:0] OE_W2 = 4'hc;
   localparam logic [3:0] OE_W4 = 4'h0;
   localparam logic [3:0] OE_OFF = 4'hf;
   // Training pattern and underrun filler
   localparam logic [3:0] DLP_LAST = 4'h4;
   localparam logic [7:0] DLP_PATTERN = 8'h5a;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   // Mode transition times
   localparam int CLK_MHZ = 40;
   localparam int QEN_NS = 1000;
   localparam int QEX_NS = 1000;
   localparam int QEN_CYC = (QEN_NS * CLK_MHZ + 999) / 1000;
   localparam int QEX_CYC = (QEX_NS * CLK_MHZ + 999) / 1000;
   localparam int TR_W = 12;
   // Read data buffer
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_LVL_W = 5;
   localparam logic [4:0] FILL_LIMIT = 5'h0f;

   // Frame sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_CMD = 7'h02,
      ST_ADDR = 7'h04,
      ST_MODE = 7'h08,
      ST_DUMMY = 7'h10,
      ST_DATA = 7'h20,
      ST_SKIP = 7'h40
   } sfr_state_t;

   // Driven side of the four data lines
   typedef struct packed {
      logic [3:0] dout;
      logic [3:0] oe_n;
   } sfr_pad_t;

   // Decoded command attributes
   typedef struct packed {
      logic rd;
      logic enter;
      logic leave;
      logic [5:0] alen;
      logic [2:0] in_w;
      logic [2:0] out_w;
      logic ddr;
      logic dummy;
      logic mode;
   } sfr_cmd_t;

   // Decode an instruction byte
   function automatic sfr_cmd_t sfr_decode(input logic [7:0] code, input logic quad,
                                           input logic alen4);
      sfr_cmd_t c;
      c = '0;
      c.alen = alen4 ? ALEN4 : ALEN3;
      c.in_w = W1;
      c.out_w = W1;
      if (code inside {CMD_READ4, CMD_FAST4, CMD_DUAL4}) begin
         c.alen = ALEN4;
      end
      if (quad) begin
         c.leave = (code == CMD_QEX);
         c.rd = (code inside {CMD_QRD, CMD_QDDR});
         c.in_w = W4;
         c.out_w = W4;
         c.dummy = 1'h1;
         c.mode = 1'h1;
         c.ddr = (code == CMD_QDDR);
      end else begin
         c.enter = (code == CMD_QEN);
         c.rd = (code inside {CMD_READ, CMD_READ4, CMD_FAST, CMD_FAST4,
                              CMD_DUAL, CMD_DUAL4});
         c.dummy = (code inside {CMD_FAST, CMD_FAST4, CMD_DUAL, CMD_DUAL4});
         c.out_w = (code inside {CMD_DUAL, CMD_DUAL4}) ? W2 : W1;
      end
      return c;
   endfunction : sfr_decode

   // Lines driven for a given output width
   function automatic logic [3:0] sfr_oe(input logic [2:0] w);
      case (w)
         W4: return OE_W4;
         W2: return OE_W2;
         default: return OE_W1;
      endcase
   endfunction : sfr_oe
endpackage : sfr_pkg

// ### hw/sfr_sync.sv
/*
 Three stage pin synchroniser with edge pulses, one lane per bit.
 Assumes pins change slower than a few system clocks.
*/
`timescale 1ns/10ps
module sfr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Raw pins
   input wire logic [W-1:0] din,
   // Accepted level and edges
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   for (genvar i = 0; i < W; i++) begin : g_lane
      logic s1; // Metastable stage, read only by s2
      logic s2;
      logic s3;
      logic lv; // Accepted level
      logic ri;
      logic fa;
      // A change counts once stages two and three agree
      always_ff @(posedge clk) begin
         if (!nrst) begin
            s1 <= INIT[i];
            s2 <= INIT[i];
            s3 <= INIT[i];
            lv <= INIT[i];
            ri <= 1'h0;
            fa <= 1'h0;
         end else begin
            s1 <= din[i];
            s2 <= s1;
            s3 <= s2;
            ri <= (s2 == s3) && s3 && !lv;
            fa <= (s2 == s3) && !s3 && lv;
            if (s2 == s3) begin
               lv <= s3;
            end
         end
      end
      assign lvl[i] = lv;
      assign rise[i] = ri;
      assign fall[i] = fa;
   end
endmodule : sfr_sync

// ### hw/sfr_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and a flush.
 Assumes DEPTH is a power of two.
*/
`timescale 1ns/10ps
module sfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock, reset and flush
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   // Occupancy
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW-1:0] wp; // Write pointer
   logic [AW-1:0] rp; // Read pointer
   logic [AW:0] cnt; // Words held
   logic push;
   logic pop;

   assign in_ready = (cnt != (AW + 1)'(DEPTH));
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   assign level = cnt;
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk) begin
      if (!nrst || flush) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= wp + AW'(1);
         end
         if (pop) begin
            rp <= rp + AW'(1);
         end
         cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : sfr_fifo

// ### hw/sfr_front_end.sv
/*
 Serial flash read front end: quad mode entry and exit, read framing,
 dummy cycles with training pattern, and data return from the array.
 Assumes the serial pins are asynchronous and sampled by clk, and that
 the array streams bytes from arr_addr upward on valid/ready.
*/
`timescale 1ns/10ps
module sfr_front_end
   import sfr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output sfr_pad_t pads,
   // Configuration inputs
   input wire logic cfg2_wr,
   input wire logic [7:0] cfg2_wr_data,
   input wire logic cfg2_nv_quad,
   input wire logic sw_reset,
   input wire logic [3:0] latency_code,
   input wire logic data_training_pattern_en,
   // Status outputs
   output logic [7:0] cfg2_volatile,
   output logic quad_command_mode,
   output logic mode_busy,
   output logic cont_read,
   // Array byte stream
   input wire logic arr_valid,
   input wire logic [7:0] arr_data,
   output logic arr_ready,
   output logic [ADDR_W-1:0] arr_addr
);
   // Synchronised pins
   logic [5:0] pin_lvl;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;
   logic sck_r; // Serial clock rising
   logic sck_f; // Serial clock falling
   logic cs_r; // Frame end
   logic cs_f; // Frame start
   logic cs_lvl; // Chip select level
   logic [3:0] io_lvl; // Data line levels

   // Frame sequencer
   sfr_state_t state;
   sfr_cmd_t cmd; // Command in progress
   sfr_cmd_t cont_cmd; // Command repeated in continuous read
   sfr_cmd_t dec; // Decode of incoming byte
   logic [31:0] sh; // Input shift register
   logic [31:0] next_sh;
   logic [5:0] bitcnt; // Bits taken in this field
   logic [5:0] next_cnt;
   logic [2:0] in_w; // Input bits per edge
   logic in_edge; // Edge that samples the lines
   logic [3:0] dcnt; // Dummy falls still to pass
   logic mode_seen; // Mode byte fully captured
   logic cont_next; // Mode byte asked for continuous read
   logic cmd_done;
   logic addr_done;
   logic boot; // First cycle after reset

   // Configuration and transition timer
   logic [7:0] next_cfg2;
   logic [TR_W-1:0] busy_cnt;
   logic [TR_W-1:0] next_busy;

   // Output shifter
   logic [7:0] obyte; // Bits left of current byte
   logic [3:0] obits; // Count of those bits
   logic [2:0] dlp_idx; // Pattern edge index
   logic out_edge;
   logic load_byte;
   logic dlp_edge;
   logic [7:0] src;
   logic [3:0] next_dout;
   logic [7:0] next_obyte;
   logic [3:0] next_obits;
   logic dlp_bit;

   // Buffer between array and shifter
   logic fetch_on;
   logic flush;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [FIFO_LVL_W-1:0] fifo_level;

   // Pin synchroniser, chip select idles high
   sfr_sync #(
      .W(6),
      .INIT(6'h02)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .din({io_in, cs_n, sck}),
      .lvl(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign sck_r = pin_rise[0];
   assign sck_f = pin_fall[0];
   assign cs_r = pin_rise[1];
   assign cs_f = pin_fall[1];
   assign cs_lvl = pin_lvl[1];
   assign io_lvl = pin_lvl[5:2];

   // Read data buffer
   sfr_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .flush(flush),
      .in_valid(arr_valid && arr_ready),
      .in_data(arr_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(load_byte),
      .level(fifo_level)
   );

   // Input sampling and instruction decode
   always_comb begin
      in_w = (state == ST_CMD) ? (quad_command_mode ? W4 : W1) : cmd.in_w;
      in_edge = !cs_lvl && (sck_r || (cmd.ddr && sck_f &&
                 (state inside {ST_ADDR, ST_MODE})));
      if (in_w == W4) begin
         next_sh = {sh[27:0], io_lvl};
      end else begin
         next_sh = {sh[30:0], io_lvl[0]};
      end
      next_cnt = bitcnt + {3'h0, in_w};
      dec = sfr_decode(next_sh[7:0], quad_command_mode, cfg2_volatile[CFG2_ALEN]);
      cmd_done = (state == ST_CMD) && in_edge && (next_cnt == CMD_BITS);
      addr_done = (state == ST_ADDR) && in_edge && (next_cnt == cmd.alen);
   end

   // Next configuration value
   always_comb begin
      next_cfg2 = cfg2_volatile;
      if (boot || sw_reset) begin
         next_cfg2 = CFG2_RST;
         next_cfg2[CFG2_QUAD] = cfg2_nv_quad;
      end else if (cfg2_wr) begin
         next_cfg2 = (cfg2_volatile & ~CFG2_WMASK) | (cfg2_wr_data & CFG2_WMASK);
      end else if (cmd_done && dec.enter) begin
         next_cfg2[CFG2_QUAD] = 1'h1;
      end else if (cmd_done && dec.leave) begin
         next_cfg2[CFG2_QUAD] = 1'h0;
      end
   end

   // Configuration register and quad mode flag
   always_ff @(posedge clk) begin
      if (!nrst) begin
         boot <= 1'h1;
         cfg2_volatile <= CFG2_RST;
         quad_command_mode <= 1'h0;
      end else begin
         boot <= 1'h0;
         cfg2_volatile <= next_cfg2;
         quad_command_mode <= next_cfg2[CFG2_QUAD];
      end
   end

   // Transition time after a mode entry or exit command
   always_comb begin
      next_busy = busy_cnt;
      if (cmd_done && dec.enter) begin
         next_busy = TR_W'(QEN_CYC);
      end else if (cmd_done && dec.leave) begin
         next_busy = TR_W'(QEX_CYC);
      end else if (busy_cnt != '0) begin
         next_busy = busy_cnt - TR_W'(1);
      end
   end

   // Transition timer register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy_cnt <= '0;
         mode_busy <= 1'h0;
      end else begin
         busy_cnt <= next_busy;
         mode_busy <= (next_busy != '0);
      end
   end

   // Frame sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cmd <= '0;
         cont_cmd <= '0;
         sh <= '0;
         bitcnt <= '0;
         dcnt <= '0;
         mode_seen <= 1'h0;
         cont_next <= 1'h0;
         cont_read <= 1'h0;
      end else if (cs_r) begin
         // Frame ends at once in any state
         state <= ST_IDLE;
         cont_read <= mode_seen && cont_next;
         mode_seen <= 1'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cs_f) begin
                  bitcnt <= '0;
                  if (mode_busy) begin
                     state <= ST_SKIP;
                  end else if (cont_read) begin
                     cmd <= cont_cmd;
                     state <= ST_ADDR;
                  end else begin
                     state <= ST_CMD;
                  end
               end
            end
            ST_CMD: begin
               if (in_edge) begin
                  sh <= next_sh;
                  bitcnt <= next_cnt;
               end
               if (cmd_done) begin
                  // Unknown or mode codes end the useful frame
                  cmd <= dec;
                  bitcnt <= '0;
                  state <= dec.rd ? ST_ADDR : ST_SKIP;
               end
            end
            ST_ADDR: begin
               if (in_edge) begin
                  sh <= next_sh;
                  bitcnt <= next_cnt;
               end
               if (addr_done) begin
                  bitcnt <= '0;
                  dcnt <= cmd.dummy ? latency_code : '0;
                  state <= cmd.mode ? ST_MODE : ST_DUMMY;
               end
            end
            ST_MODE: begin
               if (in_edge) begin
                  sh <= next_sh;
                  bitcnt <= next_cnt;
                  if (next_cnt == MODE_BITS) begin
                     mode_seen <= 1'h1;
                     cont_next <= (next_sh[7:4] == MODE_CONT);
                     cont_cmd <= cmd;
                     state <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               // Lines are not sampled here
               if (sck_f) begin
                  if (dcnt == '0) begin
                     state <= ST_DATA;
                  end else begin
                     dcnt <= dcnt - 4'h1;
                  end
               end
            end
            ST_DATA: begin
               state <= ST_DATA;
            end
            ST_SKIP: begin
               state <= ST_SKIP;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Output edge selection and byte shifting
   always_comb begin
      out_edge = (state == ST_DATA) && (sck_f || (cmd.ddr && sck_r));
      load_byte = ((state == ST_DUMMY) && sck_f && (dcnt == '0)) ||
                  (out_edge && (obits == '0));
      dlp_edge = (state == ST_DUMMY) && cmd.ddr && data_training_pattern_en &&
                 ((sck_f && (dcnt != '0) && (dcnt <= DLP_LAST)) ||
                  (sck_r && (dlp_idx != '0)));
      dlp_bit = DLP_PATTERN[3'h7 - dlp_idx];
      src = load_byte ? (fifo_out_valid ? fifo_out_data : FILL_BYTE) : obyte;
      case (cmd.out_w)
         W4: next_dout = src[7:4];
         W2: next_dout = {2'h0, src[7:6]};
         default: next_dout = {2'h0, src[7], 1'h0};
      endcase
      next_obyte = src << cmd.out_w;
      next_obits = (load_byte ? BYTE_BITS : obits) - {1'h0, cmd.out_w};
   end

   // Pad drivers; released outside data and pattern
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pads <= '{dout: 4'h0, oe_n: OE_OFF};
         obyte <= '0;
         obits <= '0;
         dlp_idx <= '0;
      end else if (cs_r || (state == ST_IDLE)) begin
         pads.oe_n <= OE_OFF;
         obits <= '0;
         dlp_idx <= '0;
      end else if (dlp_edge) begin
         pads.dout <= {4{dlp_bit}};
         pads.oe_n <= sfr_oe(cmd.out_w);
         dlp_idx <= dlp_idx + 3'h1;
      end else if (load_byte || out_edge) begin
         pads.dout <= next_dout;
         pads.oe_n <= sfr_oe(cmd.out_w);
         obyte <= next_obyte;
         obits <= next_obits;
      end
   end

   // Buffer cleared at each new address and at frame end
   assign flush = cs_r || addr_done;

   // Array fetch address and back-pressure
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fetch_on <= 1'h0;
         arr_addr <= '0;
         arr_ready <= 1'h0;
      end else begin
         if (cs_r) begin
            fetch_on <= 1'h0;
         end else if (addr_done) begin
            fetch_on <= 1'h1;
            arr_addr <= next_sh[ADDR_W-1:0];
         end else if (arr_valid && arr_ready) begin
            arr_addr <= arr_addr + ADDR_W'(1);
         end
         arr_ready <= fetch_on && !flush && fifo_in_ready && (fifo_level < FILL_LIMIT);
      end
   end
endmodule : sfr_front_end

// ### bench/sfr_assertions.sv
/*
 Port checker of the serial flash read front end.
 Assumes the 40 MHz clk and the sync reset nrst; bound below.
*/
`timescale 1ns/10ps
module sfr_assertions
   import sfr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link and configuration
   input wire logic cs_n,
   input wire sfr_pad_t pads,
   input wire logic cfg2_wr,
   input wire logic [7:0] cfg2_wr_data,
   input wire logic cfg2_nv_quad,
   input wire logic sw_reset,
   // Status and array stream
   input wire logic [7:0] cfg2_volatile,
   input wire logic quad_command_mode,
   input wire logic mode_busy,
   input wire logic cont_read,
   input wire logic arr_valid,
   input wire logic arr_ready,
   input wire logic [ADDR_W-1:0] arr_addr
);
   // Length of the present busy stretch
   logic [6:0] busy_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Count busy cycles, cleared while idle
   always_ff @(posedge clk) begin
      if (!nrst || !mode_busy) begin
         busy_cnt <= 7'h00;
      end else begin
         busy_cnt <= busy_cnt + 7'h01;
      end
   end
   quad_mirror_a: assert property (quad_command_mode == cfg2_volatile[3])
      else $error("quad flag differs from cfg2 bit");
   cfg_write_a: assert property (cfg2_wr && !sw_reset |=>
      (cfg2_volatile & CFG2_WMASK) == ($past(cfg2_wr_data) & CFG2_WMASK))
      else $error("cfg2 write not taken");
   soft_reset_a: assert property (sw_reset && !cfg2_wr |=>
      cfg2_volatile == {4'h0, $past(cfg2_nv_quad), 3'h0})
      else $error("soft reset value wrong");
   cfg_stable_a: assert property (cs_n [*8] ##0
      (!cfg2_wr && !sw_reset && $past(nrst)) |=> $stable(cfg2_volatile))
      else $error("cfg2 changed without cause");
   busy_len_a: assert property ($fell(mode_busy) |-> busy_cnt inside {[7'd39:7'd42]})
      else $error("transition time wrong");
   pads_off_a: assert property (cs_n [*8] |-> pads.oe_n == OE_OFF)
      else $error("pads driven while deselected");
   single_lanes_a: assert property (!quad_command_mode |-> pads.oe_n[3:2] == 2'h3)
      else $error("upper lines driven in single mode");
   addr_step_a: assert property (arr_valid && arr_ready |=>
      arr_addr == $past(arr_addr) + 24'h000001)
      else $error("array address did not step");
   cont_set_a: assert property ($rose(cont_read) |-> cs_n && !$past(cs_n, 8))
      else $error("continuous read set outside frame end");
endmodule : sfr_assertions
bind sfr_front_end sfr_assertions i_sfr_assertions (.clk, .nrst, .cs_n, .pads, .cfg2_wr,
   .cfg2_wr_data, .cfg2_nv_quad, .sw_reset, .cfg2_volatile, .quad_command_mode,
   .mode_busy, .cont_read, .arr_valid, .arr_ready, .arr_addr);

// ### bench/sfr_host_model.sv
/*
 Host controller model: owns sck, cs_n and its io drive.
 Assumes the bench resolves the wire and calls these tasks.
*/
`timescale 1ns/10ps
module sfr_host_model (
   // Serial link driven
   output logic sck,
   output logic cs_n,
   output logic [3:0] io,
   // Resolved wire
   input wire logic [3:0] wire_io
);
   // Idle link, clock low
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io = 4'h0;
   end
   // One cycle: fall with new value, rise after half period
   task automatic tick(input logic [3:0] v);
      sck = 1'b0;
      io = v;
      #100 sck = 1'b1;
      #100;
   endtask : tick
   // Select or deselect; clock set low 400 ns after the change, so it stays high for 400 ns after a deselect
   task automatic sel(input logic on);
      cs_n = !on;
      #400 sck = 1'b0;
   endtask : sel
   // Send n bits, w per rising edge, top bit first
   task automatic put(input logic [31:0] v, input int n, input int w);
      for (int i = n - w; i >= 0; i -= w) begin
         tick(w == 4 ? v[i +: 4] : {3'h0, v[i]});
      end
   endtask : put
   // Dummy cycles with lines released to a toggling pattern
   task automatic idle(input int n);
      repeat (n) tick(~io);
   endtask : idle
   // Take one byte, w bits per falling edge
   task automatic get(input int w, output logic [7:0] b);
      for (int i = 0; i < 8 / w; i++) begin
         tick(~io);
         b = w == 1 ? {b[6:0], wire_io[1]} : w == 2 ? {b[5:0], wire_io[1:0]}
            : {b[3:0], wire_io};
      end
   endtask : get
endmodule : sfr_host_model

// ### bench/sfr_front_end_tb.sv
/*
 Bench of the read front end with host and array models.
 Assumes sfr_pkg; inputs change on the falling clk edge.
*/
`timescale 1ns/10ps
module sfr_front_end_tb
   import sfr_pkg::*;
;
   // Inputs, valued at time zero
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cfg2_wr = 1'b0;
   logic [7:0] cfg2_wr_data = 8'h00;
   logic cfg2_nv_quad = 1'b0;
   logic sw_reset = 1'b0;
   logic [3:0] latency_code = 4'h0;
   logic arr_valid = 1'b0;
   logic [7:0] arr_data = 8'h00;
   // Link and outputs
   logic sck;
   logic cs_n;
   logic [3:0] host_io;
   logic [3:0] wire_io;
   sfr_pad_t pads;
   logic [7:0] cfg2_volatile;
   logic quad_command_mode;
   logic mode_busy;
   logic cont_read;
   logic arr_ready;
   logic [ADDR_W-1:0] arr_addr;
   // Counters and single mode read codes
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] cmds [6] = '{CMD_READ, CMD_READ4, CMD_FAST, CMD_FAST4, CMD_DUAL, CMD_DUAL4};
   always #12.5 clk = ~clk;
   // Wire level: device where enabled, host elsewhere
   assign wire_io = (pads.oe_n & host_io) | (~pads.oe_n & pads.dout);
   sfr_front_end i_sfr_front_end (.clk, .nrst, .sck, .cs_n, .io_in(wire_io), .pads,
      .cfg2_wr, .cfg2_wr_data, .cfg2_nv_quad, .sw_reset, .latency_code,
      .data_training_pattern_en(1'b0), .cfg2_volatile, .quad_command_mode, .mode_busy,
      .cont_read, .arr_valid, .arr_data, .arr_ready, .arr_addr);
   sfr_host_model i_sfr_host_model (.sck, .cs_n, .io(host_io), .wire_io);
   // Array content of an address
   function automatic logic [7:0] exb(input logic [23:0] x);
      return x[7:0] ^ x[15:8] ^ x[23:16];
   endfunction : exb
   // Array model, stalling one clock in eight
   always @(negedge clk) begin
      arr_valid <= cyc[2:0] != 3'h7;
      arr_data <= exb(arr_addr);
   end
   // Verdict and end of run
   task automatic close_out;
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   // Run ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         $display("mismatch %0t run too long", $time);
         close_out();
      end
   end
   // Compare one value
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // Pulse a cfg2 write or a soft reset
   task automatic cfg(input logic [7:0] d, input logic sr);
      @(negedge clk);
      cfg2_wr_data = d;
      cfg2_wr = !sr;
      sw_reset = sr;
      @(negedge clk);
      cfg2_wr = 1'b0;
      sw_reset = 1'b0;
      @(negedge clk);
   endtask : cfg
   // Instruction-only frame
   task automatic op(input logic [7:0] code, input int w);
      i_sfr_host_model.sel(1'b1);
      i_sfr_host_model.put({24'h0, code}, 8, w);
      i_sfr_host_model.sel(1'b0);
   endtask : op
   // Read frame of three bytes; code 00 omits the instruction, md[8] adds mode
   task automatic rd(input logic [7:0] code, input logic [31:0] a, input int an,
                     input logic [8:0] md, input int lc, input int w);
      logic [7:0] b;
      @(negedge clk);
      latency_code = 4'(lc);
      i_sfr_host_model.sel(1'b1);
      if (code != 8'h00) begin
         i_sfr_host_model.put({24'h0, code}, 8, quad_command_mode ? 4 : 1);
      end
      i_sfr_host_model.put(a, an, w == 4 ? 4 : 1);
      if (md[8]) begin
         i_sfr_host_model.put({24'h0, md[7:0]}, 8, 4);
      end
      i_sfr_host_model.idle(lc);
      for (int k = 0; k < 3; k++) begin
         i_sfr_host_model.get(w, b);
         chk(b, exb(a[23:0] + 24'(k)), "read byte");
      end
      i_sfr_host_model.sel(1'b0);
   endtask : rd
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
      foreach (cmds[j]) begin
         rd(cmds[j], 32'h5aff_fffe, 24 + 8 * j[0], 9'h0, j & 6, 1 + j[2]);
      end
      cfg(8'h01, 1'b0);
      chk(cfg2_volatile, 8'h01, "alen");
      rd(CMD_FAST, 32'ha5ff_ffff, 32, 9'h0, 1, 1);
      cfg(8'h00, 1'b0);
      op(CMD_QEN, 1);
      chk({7'h0, mode_busy}, 8'h01, "busy");
      chk(cfg2_volatile, 8'h08, "quad on");
      chk({7'h0, quad_command_mode}, 8'h01, "quad flag");
      repeat (50) @(negedge clk);
      rd(CMD_QRD, 32'h0000_2000, 24, 9'h1a5, 4, 4);
      chk({7'h0, cont_read}, 8'h01, "cont on");
      rd(8'h00, 32'h0000_3000, 24, 9'h100, 4, 4);
      chk({7'h0, cont_read}, 8'h00, "cont off");
      op(CMD_QEX, 4);
      chk(cfg2_volatile, 8'h00, "quad off");
      chk({7'h0, quad_command_mode}, 8'h00, "quad flag off");
      repeat (50) @(negedge clk);
      cfg(8'h08, 1'b0);
      chk(cfg2_volatile, 8'h08, "wr quad");
      cfg(8'h00, 1'b0);
      chk(cfg2_volatile, 8'h00, "wr clear");
      cfg2_nv_quad = 1'b1;
      cfg(8'h00, 1'b1);
      chk(cfg2_volatile, 8'h08, "soft reset");
      cfg2_nv_quad = 1'b0;
      nrst = 1'b0;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      chk(cfg2_volatile, 8'h00, "hard reset");
      close_out();
   end
endmodule : sfr_front_end_tb
